// >>> design/adc_control_register_bank.sv
// Serial control register bank and output control of the dual converter
`timescale 1ns/1ps
`default_nettype none
`include "adc_ctrl_map.svh"
// Function
// R1 - Mode 00 normal; host avoids code 11
// R2 - Mode 01 outputs fixed 14-bit pattern
// R3 - Mode 10 outputs user pattern registers
// R4 - Lane bit clear: split over both lanes
// R5 - Lane bit set: second lane only
// R6 - Bit four enables duty cycle stabilizer
// R7 - Bit three selects two's complement format
// R8 - Host keeps alignment clear in single lane
// R9 - Alignment clear: words staggered half word
// R10 - Alignment set: second lane delayed cycle
// R11 - Bit one powers down channel A
// R12 - Bit zero powers down channel B
// R13 - Control register address zero, reset 08h
// R14 - Address one holds pattern bits 13:8
// R15 - Host writes zero to reserved bits
// R16 - Address two holds pattern low byte
// R17 - Exactly sixteen clocks; short frames discarded
// R18 - Serial enable selects registers over pins
// R19 - First bit one reads, zero writes
// R20 - Reads return stored value, no effect
module adc_control_register_bank (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Serial control interface
    input wire logic serial_enable,
    input wire logic serial_select_n,
    input wire logic sclk,
    input wire logic sdi,
    output logic sdo,
    output logic sdo_oe,
    // Direct control pins
    input wire logic pin_test,
    input wire logic pin_lane_cfg,
    input wire logic pin_dcs,
    input wire logic pin_format,
    input wire logic pin_align,
    input wire logic pin_pd_a,
    input wire logic pin_pd_b,
    // Converter core samples, offset binary
    input wire adc_ctrl_pkg::sample_t sample_a,
    input wire adc_ctrl_pkg::sample_t sample_b,
    // Output words towards the serializer
    output adc_ctrl_pkg::sample_t word_a,
    output adc_ctrl_pkg::sample_t word_b,
    // Lane, clock and power-down control
    output logic first_data_lane_oe_a,
    output logic first_data_lane_oe_b,
    output logic dual_lane,
    output logic word_stagger,
    output logic second_lane_delay,
    output logic dcs_enable,
    output logic powerdown_a,
    output logic powerdown_b
);
    import adc_ctrl_pkg::*;

    logic sclk_ff;
    logic select_n_ff;
    logic [4:0] bit_cnt_ff;
    logic [15:0] shift_ff;
    logic [1:0] addr_ff;
    logic sdo_ff;
    sample_t word_a_ff;
    sample_t word_b_ff;
    logic [4:0] nxt_bit_cnt;
    logic [15:0] nxt_shift;
    reg_byte_t ctrl_q;
    reg_byte_t pat_hi_q;
    reg_byte_t pat_lo_q;
    reg_byte_t read_byte;

    // Edge detection of serial clock and select on the converter clock
    wire sclk_rise = sclk & ~sclk_ff;
    wire sclk_fall = ~sclk & sclk_ff;
    wire frame_end = serial_select_n & ~select_n_ff;
    wire in_frame = ~serial_select_n;

    // Frame completes only with exactly sixteen bits shifted in
    wire frame_full = (bit_cnt_ff == `FRAME_BITS); // [R17]
    wire frame_read = shift_ff[`FRAME_RW_BIT]; // [R19]
    wire [1:0] frame_addr = shift_ff[`FRAME_ADDR_HI:`FRAME_ADDR_LO];
    wire reg_byte_t frame_data = shift_ff[`FRAME_DATA_HI:0];
    wire commit = frame_end & frame_full & serial_enable; // [R17]
    wire do_write = commit & ~frame_read; // [R19]
    wire wr_ctrl = do_write & (frame_addr == `ADDR_DEVICE_CONTROL); // [R13]
    wire wr_pat_hi = do_write & (frame_addr == `ADDR_PATTERN_UPPER); // [R14]
    wire wr_pat_lo = do_write & (frame_addr == `ADDR_PATTERN_LOWER); // [R16]

    // Bit counter saturates so over-long frames never look complete
    assign nxt_bit_cnt = (bit_cnt_ff == `CNT_MAX) ? bit_cnt_ff
                       : bit_cnt_ff + `CNT_ONE;
    assign nxt_shift = {shift_ff[14:0], sdi};

    // Serial front end; a new select assertion restarts the frame
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sclk_ff <= 1'b0;
            select_n_ff <= 1'b1;
            bit_cnt_ff <= 5'h00;
            shift_ff <= 16'h0000;
        end else begin
            sclk_ff <= sclk;
            select_n_ff <= serial_select_n;
            if (serial_select_n) begin
                bit_cnt_ff <= 5'h00;
            end else if (sclk_rise) begin
                bit_cnt_ff <= nxt_bit_cnt;
                shift_ff <= nxt_shift;
            end
        end
    end

    // Address is kept only from complete frames, default zero
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            addr_ff <= `ADDR_DEVICE_CONTROL;
        end else if (commit) begin
            addr_ff <= frame_addr; // [R17]
        end
    end

    ctrl_reg #(.RESET_VALUE(`RST_DEVICE_CONTROL)) u_device_control (
        .mclk(mclk),
        .rst(rst),
        .wr_en(wr_ctrl),
        .wr_data(frame_data),
        .value(ctrl_q)
    );

    ctrl_reg #(.RESET_VALUE(`RST_PATTERN_UPPER)) u_user_pattern_upper (
        .mclk(mclk),
        .rst(rst),
        .wr_en(wr_pat_hi),
        .wr_data(frame_data),
        .value(pat_hi_q)
    );

    ctrl_reg #(.RESET_VALUE(`RST_PATTERN_LOWER)) u_user_pattern_lower (
        .mclk(mclk),
        .rst(rst),
        .wr_en(wr_pat_lo),
        .wr_data(frame_data),
        .value(pat_lo_q)
    );

    // Read mux over the stored address; reserved bits come back as stored
    assign read_byte = (addr_ff == `ADDR_DEVICE_CONTROL) ? ctrl_q
                     : (addr_ff == `ADDR_PATTERN_UPPER) ? pat_hi_q
                     : (addr_ff == `ADDR_PATTERN_LOWER) ? pat_lo_q
                     : `ZERO_BYTE; // [R20]
    wire [4:0] sdo_idx_full = `FRAME_BITS - bit_cnt_ff;
    wire [2:0] sdo_idx = sdo_idx_full[2:0];
    wire sdo_slot = (bit_cnt_ff >= `SDO_FIRST) & (bit_cnt_ff <= `FRAME_BITS);

    // Read data leaves msb first on falling edges nine to sixteen
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sdo_ff <= 1'b0;
        end else if (serial_select_n) begin
            sdo_ff <= 1'b0;
        end else if (sclk_fall & sdo_slot) begin
            sdo_ff <= read_byte[sdo_idx]; // [R20]
        end
    end

    assign sdo = sdo_ff;
    assign sdo_oe = in_frame & serial_enable;

    // Registers govern while serial access is enabled, else the pins
    wire op_mode_t reg_mode = op_mode_t'(ctrl_q[`MODE_HI:`MODE_LO]);
    wire op_mode_t pin_mode = pin_test ? mode_fixed_pattern : mode_normal;
    wire op_mode_t eff_mode = serial_enable ? reg_mode : pin_mode; // [R18]
    wire lane_single = serial_enable ? ctrl_q[`LANE_CFG_BIT]
                     : pin_lane_cfg; // [R18]
    wire align_set = serial_enable ? ctrl_q[`ALIGN_BIT] : pin_align;
    wire twos_comp = serial_enable ? ctrl_q[`FORMAT_BIT] : pin_format;
    assign dcs_enable = serial_enable ? ctrl_q[`DCS_BIT] : pin_dcs; // [R6]
    assign powerdown_a = serial_enable ? ctrl_q[`PD_A_BIT]
                       : pin_pd_a; // [R11]
    assign powerdown_b = serial_enable ? ctrl_q[`PD_B_BIT]
                       : pin_pd_b; // [R12]

    // Lane control; alignment is only honoured in dual-lane mode
    assign dual_lane = ~lane_single; // [R4]
    assign first_data_lane_oe_a = ~lane_single; // [R5]
    assign first_data_lane_oe_b = ~lane_single; // [R5]
    assign word_stagger = ~lane_single & ~align_set; // [R9]
    assign second_lane_delay = ~lane_single & align_set; // [R10]

    // Pattern assembly and number format; reserved mode behaves as normal
    wire sample_t user_pat = {pat_hi_q[`PAT_UPPER_HI:0], pat_lo_q}; // [R3]
    wire sample_t conv_a = twos_comp ? {~sample_a[13], sample_a[12:0]}
                         : sample_a; // [R7]
    wire sample_t conv_b = twos_comp ? {~sample_b[13], sample_b[12:0]}
                         : sample_b; // [R7]
    sample_t sel_a;
    sample_t sel_b;

    always_comb begin
        case (eff_mode)
            mode_fixed_pattern: begin
                sel_a = `FIXED_PATTERN; // [R2]
                sel_b = `FIXED_PATTERN; // [R2]
            end
            mode_user_pattern: begin
                sel_a = user_pat; // [R3]
                sel_b = user_pat; // [R3]
            end
            default: begin
                sel_a = conv_a; // [R1]
                sel_b = conv_b; // [R1]
            end
        endcase
    end

    // Output words; a powered-down channel parks at zero
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            word_a_ff <= `ZERO_WORD;
            word_b_ff <= `ZERO_WORD;
        end else begin
            word_a_ff <= powerdown_a ? `ZERO_WORD : sel_a; // [R11]
            word_b_ff <= powerdown_b ? `ZERO_WORD : sel_b; // [R12]
        end
    end

    assign word_a = word_a_ff;
    assign word_b = word_b_ff;
endmodule
`default_nettype wire

// >>> design/adc_ctrl_map.svh
// Register offsets, field positions, reset values and serial frame layout
`ifndef ADC_CTRL_MAP_SVH
`define ADC_CTRL_MAP_SVH
`define ADDR_DEVICE_CONTROL 2'h0
`define ADDR_PATTERN_UPPER 2'h1
`define ADDR_PATTERN_LOWER 2'h2
`define RST_DEVICE_CONTROL 8'h08
`define RST_PATTERN_UPPER 8'h00
`define RST_PATTERN_LOWER 8'h00
`define MODE_HI 7
`define MODE_LO 6
`define LANE_CFG_BIT 5
`define DCS_BIT 4
`define FORMAT_BIT 3
`define ALIGN_BIT 2
`define PD_A_BIT 1
`define PD_B_BIT 0
`define PAT_UPPER_HI 5
`define FIXED_PATTERN 14'h298e
`define FRAME_BITS 5'h10
`define FRAME_RW_BIT 15
`define FRAME_ADDR_HI 9
`define FRAME_ADDR_LO 8
`define FRAME_DATA_HI 7
`define SDO_FIRST 5'h09
`define CNT_MAX 5'h1f
`define CNT_ONE 5'h01
`define ZERO_WORD 14'h0000
`define ZERO_BYTE 8'h00
`endif

// >>> design/adc_ctrl_pkg.sv
// Types shared by the control register bank
package adc_ctrl_pkg;
    typedef enum logic [1:0] {
        mode_normal,
        mode_fixed_pattern,
        mode_user_pattern,
        mode_reserved
    } op_mode_t;
    typedef logic [13:0] sample_t;
    typedef logic [7:0] reg_byte_t;
endpackage

// >>> design/ctrl_reg.sv
// One byte-wide control register with write enable and reset value
`timescale 1ns/1ps
`default_nettype none
module ctrl_reg #(
    parameter logic [7:0] RESET_VALUE = 8'h00
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Write port
    input wire logic wr_en,
    input wire logic [7:0] wr_data,
    // Stored value
    output logic [7:0] value
);
    logic [7:0] value_ff;

    // Holds its value until a completed write frame updates it
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            value_ff <= RESET_VALUE;
        end else if (wr_en) begin
            value_ff <= wr_data;
        end
    end

    assign value = value_ff;
endmodule
`default_nettype wire

// >>> sim/adc_ctrl_properties.sv
// Port-level assertions for the control register bank
`timescale 1ns/1ps
`default_nettype none
module adc_ctrl_properties (
    // Clock, reset and controls
    input wire logic mclk,
    input wire logic rst,
    input wire logic serial_enable,
    input wire logic serial_select_n,
    input wire logic pin_test,
    input wire logic pin_format,
    input wire logic pin_pd_a,
    input wire logic pin_pd_b,
    input wire adc_ctrl_pkg::sample_t sample_a,
    // Outputs
    input wire adc_ctrl_pkg::sample_t word_a,
    input wire adc_ctrl_pkg::sample_t word_b,
    input wire logic sdo_oe,
    input wire logic first_data_lane_oe_a,
    input wire logic dual_lane,
    input wire logic word_stagger,
    input wire logic second_lane_delay,
    input wire logic powerdown_a,
    input wire logic powerdown_b
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    // Lane and alignment outputs must never contradict each other
    a_lane_oe: assert property (first_data_lane_oe_a == dual_lane)
        else $error("first lane enable disagrees with lane mode");
    a_stagger_dual: assert property (
        word_stagger |-> dual_lane && !second_lane_delay)
        else $error("stagger outside dual lane");
    a_delay_dual: assert property (
        second_lane_delay |-> dual_lane && !word_stagger)
        else $error("lane delay outside dual lane");
    // Read data may only be driven inside an enabled frame
    a_sdo_drive: assert property (
        sdo_oe == (!serial_select_n && serial_enable))
        else $error("read data enable outside enabled frame");
    // Words are registered, so a power-down shows one cycle later
    a_pd_a_zero: assert property (powerdown_a |=> word_a == 14'h0000)
        else $error("channel A word not zero in power-down");
    a_pd_b_zero: assert property (powerdown_b |=> word_b == 14'h0000)
        else $error("channel B word not zero in power-down");
    a_pin_govern: assert property (!serial_enable |->
        powerdown_a == pin_pd_a && powerdown_b == pin_pd_b)
        else $error("pins do not govern with serial port off");
    a_fixed_word: assert property (
        !serial_enable && pin_test && !pin_pd_a |=> word_a == 14'h298e)
        else $error("fixed pattern missing");
    a_offset_fmt: assert property (
        !serial_enable && !pin_test && !pin_pd_a && !pin_format
        |=> word_a == $past(sample_a))
        else $error("offset binary word altered");
    c_single: cover property (!dual_lane);
    c_both_pd: cover property (powerdown_a && powerdown_b);
    c_pin_test: cover property (!serial_enable && pin_test);
endmodule
bind adc_control_register_bank adc_ctrl_properties i_props (.mclk(mclk),
    .rst(rst), .serial_enable(serial_enable),
    .serial_select_n(serial_select_n), .sdo_oe(sdo_oe), .pin_test(pin_test),
    .pin_format(pin_format), .pin_pd_a(pin_pd_a), .pin_pd_b(pin_pd_b),
    .sample_a(sample_a), .word_a(word_a), .word_b(word_b),
    .first_data_lane_oe_a(first_data_lane_oe_a), .dual_lane(dual_lane),
    .word_stagger(word_stagger), .second_lane_delay(second_lane_delay),
    .powerdown_a(powerdown_a), .powerdown_b(powerdown_b));
`default_nettype wire

// >>> sim/serial_host.sv
// Host model driving the four-wire serial control port
`timescale 1ns/1ps
`default_nettype none
module serial_host (
    // Clock and read data
    input wire logic mclk,
    input wire logic sdo,
    // Serial control lines
    output logic serial_select_n,
    output logic sclk,
    output logic sdi
);
    initial begin
        serial_select_n = 1'b1;
        sclk = 1'b0;
        sdi = 1'b0;
    end
    // Sclk stays high two mclk cycles and low four so the sampler sees each level
    task automatic xfer(input logic [15:0] w, input int n,
                        output logic [7:0] rd);
        rd = 8'h00;
        @(posedge mclk);
        #1 serial_select_n = 1'b0;
        for (int i = 0; i < n; i++) begin
            sdi = w[15 - i];
            repeat (2) @(posedge mclk);
            #1 sclk = 1'b1;
            repeat (2) @(posedge mclk);
            #1 sclk = 1'b0;
            repeat (2) @(posedge mclk);
            if (i > 7) rd[15 - i] = sdo;
            #1;
        end
        serial_select_n = 1'b1;
        // Idle data line must not look like a held bit
        sdi = ~sdi;
        repeat (3) @(posedge mclk);
        #1;
    endtask
endmodule
`default_nettype wire

// >>> sim/tb_adc_control_register_bank.sv
// Self-checking bench for the control register bank
`timescale 1ns/1ps
`default_nettype none
module tb_adc_control_register_bank;
    import adc_ctrl_pkg::*;
    logic mclk, rst, sen, sel_n, sclk, sdi, sdo;
    logic [6:0] pins;
    sample_t sa, sb, wa, wb;
    wire [7:0] fl;
    logic [7:0] rd, up, lo;
    logic [31:0] seed = 32'h3604_8ad2;
    logic [17:0] exp_q[$];
    logic [17:0] e;
    logic [7:0] ctl[7] = '{8'h28, 8'h00, 8'h14, 8'h02, 8'h41, 8'h89,
        8'h08};
    logic [6:0] pv[2] = '{7'h55, 7'h08};
    int err_count, num_checks;
    adc_control_register_bank i_dut (.mclk(mclk), .rst(rst),
        .serial_enable(sen), .serial_select_n(sel_n), .sclk(sclk),
        .sdi(sdi), .sdo(sdo), .sdo_oe(), .pin_test(pins[6]),
        .pin_lane_cfg(pins[5]), .pin_dcs(pins[4]), .pin_format(pins[3]),
        .pin_align(pins[2]), .pin_pd_a(pins[1]), .pin_pd_b(pins[0]),
        .sample_a(sa), .sample_b(sb), .word_a(wa), .word_b(wb),
        .first_data_lane_oe_a(fl[7]), .first_data_lane_oe_b(fl[6]),
        .dual_lane(fl[5]), .word_stagger(fl[4]), .second_lane_delay(fl[3]),
        .dcs_enable(fl[2]), .powerdown_a(fl[1]), .powerdown_b(fl[0]));
    serial_host i_host (.mclk(mclk), .sdo(sdo), .serial_select_n(sel_n),
        .sclk(sclk), .sdi(sdi));
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        return x ^ (x << 5);
    endfunction
    // Flag byte in the bit order wired into fl
    function automatic logic [7:0] fexp(input logic [7:0] c);
        logic d;
        d = !c[5];
        return {d, d, d, d & !c[2], d & c[2], c[4], c[1], c[0]};
    endfunction
    function automatic sample_t wexp(input logic [7:0] c, input sample_t s,
                                     input logic p);
        if (p) return 14'h0000;
        if (c[7:6] == 2'b01) return 14'h298e;
        if (c[7:6] == 2'b10) return {up[5:0], lo};
        return {s[13] ^ c[3], s[12:0]};
    endfunction
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic note(input logic [1:0] s, input logic [15:0] v);
        exp_q.push_back({s, v});
    endtask
    // Lets the monitor read outputs before inputs move again
    task automatic tick();
        @(posedge mclk);
        #1;
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    initial begin
        #100000;
        err_count++;
        end_of_test();
    end
    // Monitor: compares the named output with the oldest note
    initial forever begin
        wait (exp_q.size() > 0);
        e = exp_q.pop_front();
        case (e[17:16])
            2'h0: check({8'h00, rd}, e[15:0]);
            2'h1: check({2'b00, wa}, e[15:0]);
            2'h2: check({2'b00, wb}, e[15:0]);
            default: check({8'h00, fl}, e[15:0]);
        endcase
    end
    initial begin
        rst = 1'b1;
        sen = 1'b1;
        pins = 7'h00;
        sa = 14'h0000;
        sb = 14'h0000;
        repeat (2) @(posedge mclk);
        #1 rst = 1'b0;
        i_host.xfer(16'h8000, 16, rd);
        note(0, 8'h08);
        note(3, fexp(8'h08));
        $display("reset test done");
        seed = xs(seed);
        up = {2'b00, seed[5:0]};
        lo = seed[15:8];
        i_host.xfer({8'h01, up}, 16, rd);
        i_host.xfer(16'h8000, 16, rd);
        note(0, up);
        i_host.xfer({8'h02, lo}, 16, rd);
        i_host.xfer(16'h8000, 16, rd);
        note(0, lo);
        $display("pattern test done");
        foreach (ctl[i]) begin
            tick();
            seed = xs(seed);
            sa = seed[13:0];
            sb = seed[29:16];
            i_host.xfer({8'h00, ctl[i]}, 16, rd);
            i_host.xfer(16'h8000, 16, rd);
            note(0, ctl[i]);
            note(3, fexp(ctl[i]));
            note(1, wexp(ctl[i], sa, ctl[i][1]));
            note(2, wexp(ctl[i], sb, ctl[i][0]));
        end
        $display("control test done");
        tick();
        i_host.xfer(16'h0103, 15, rd);
        i_host.xfer(16'h8000, 16, rd);
        note(0, 8'h08);
        note(3, fexp(8'h08));
        $display("short frame test done");
        sen = 1'b0;
        foreach (pv[i]) begin
            tick();
            pins = pv[i];
            tick();
            tick();
            note(3, fexp({1'b0, pv[i]}));
            note(1, wexp({1'b0, pv[i]}, sa, pv[i][1]));
            note(2, wexp({1'b0, pv[i]}, sb, pv[i][0]));
        end
        tick();
        i_host.xfer(16'h0003, 16, rd);
        sen = 1'b1;
        pins = pv[0];
        i_host.xfer(16'h8000, 16, rd);
        note(0, 8'h08);
        note(3, fexp(8'h08));
        $display("pin test done");
        tick();
        end_of_test();
    end
endmodule
`default_nettype wire
